// >>> verilog/hv_drv_pkg.sv
package hv_drv_pkg;
	localparam int CODE_W    = 14;
	localparam int CFG_AW    = 5;
	localparam int CFG_DW    = 16;
	localparam int PAT_DEPTH = 16;
	localparam int PAT_AW    = 4;
	localparam int FAULT_N   = 5;
	localparam int LIM_W     = 8;
	localparam int DUR_W     = 16;

	// device configuration map, one word per index
	localparam logic [CFG_AW-1:0] REG_CTRL      = 5'h00;
	localparam logic [CFG_AW-1:0] REG_FAULT_EN  = 5'h01;
	localparam logic [CFG_AW-1:0] REG_LATCH     = 5'h02;
	localparam logic [CFG_AW-1:0] REG_ALARM_CLR = 5'h03;
	localparam logic [CFG_AW-1:0] REG_DURATION  = 5'h04;
	localparam logic [CFG_AW-1:0] REG_LIM_BASE  = 5'h05;
	localparam logic [CFG_AW-1:0] REG_PAT_BASE  = 5'h10;

	// control word fields
	localparam int CTRL_PATTERN_BIT = 0;
	localparam int CTRL_ARM_BIT     = 1;
	localparam int CTRL_RESTART_BIT = 2;
	localparam int CTRL_SLEEP_BIT   = 3;
	localparam int CTRL_LAST_LSB    = 4;

	// fault order: source oc, sink oc, positive ov, negative ov, overtemp
	localparam int FLT_SRC_OC = 0;
	localparam int FLT_SNK_OC = 1;
	localparam int FLT_POS_OV = 2;
	localparam int FLT_NEG_OV = 3;
	localparam int FLT_TEMP   = 4;

	localparam logic [CFG_DW-1:0]  CTRL_RESET     = 16'h0008;
	localparam logic [FAULT_N-1:0] FAULT_EN_RESET = 5'h1F;
	localparam logic [DUR_W-1:0]   DUR_RESET      = 16'h0010;
	localparam logic [LIM_W-1:0]   LIM_RESET      = 8'hFF;

	// controller wishbone map (byte addresses)
	localparam logic [7:0] WB_CFG     = 8'h00;
	localparam logic [7:0] WB_STROBE  = 8'h04;
	localparam logic [7:0] WB_CODE    = 8'h08;
	localparam logic [7:0] WB_PINS    = 8'h0C;
	localparam logic [7:0] WB_STATUS  = 8'h10;
	localparam logic [7:0] WB_RESTART = 8'h14;

	localparam int WB_CODE_DRV_BIT = 16;
	localparam int WB_CFG_ADR_LSB  = 16;

	// wait for a charged shutdown pin to discharge: 1000 ns at 40 ns
	localparam int CLK_PERIOD_NS  = 40;
	localparam int SDN_SETTLE_NS  = 1000;
	localparam int SDN_SETTLE_CYC = (SDN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : hv_drv_pkg

// >>> verilog/hv_link_if.sv
`timescale 1ns/10ps
interface hv_link_if;
	import hv_drv_pkg::*;

	logic                cfg_wr;
	logic [CFG_AW-1:0]   cfg_addr;
	logic [CFG_DW-1:0]   cfg_data;
	logic                strobe;
	logic [CODE_W-1:0]   host_bus_out;
	logic                host_bus_oe_n;
	logic [CODE_W-1:0]   dev_bus_out;
	logic                dev_bus_oe_n;
	logic [CODE_W-1:0]   bus_level;
	logic                host_sdn_out;
	logic                host_sdn_oe_n;
	logic                dev_sdn_out;
	logic                dev_sdn_oe_n;
	logic                sdn_level;
	logic                sdn_forced_low;
	logic                clear_pin;

	// undriven wires read low; the host wins a fight
	assign bus_level      = !host_bus_oe_n ? host_bus_out : (!dev_bus_oe_n ? dev_bus_out : '0);
	assign sdn_level      = !host_sdn_oe_n ? host_sdn_out : (!dev_sdn_oe_n ? dev_sdn_out : 1'b0);
	assign sdn_forced_low = !host_sdn_oe_n && !host_sdn_out;

	modport device (
		input  cfg_wr, cfg_addr, cfg_data, strobe, bus_level, sdn_level, sdn_forced_low, clear_pin,
		output dev_bus_out, dev_bus_oe_n, dev_sdn_out, dev_sdn_oe_n
	);
	modport host (
		input  bus_level, sdn_level,
		output cfg_wr, cfg_addr, cfg_data, strobe, host_bus_out, host_bus_oe_n,
		output host_sdn_out, host_sdn_oe_n, clear_pin
	);
endinterface : hv_link_if

// >>> verilog/hv_driver_core.sv
// Design decisions made here: the configuration link (cfg_wr, cfg_addr, cfg_data) to the registers and the register addresses.
`timescale 1ns/10ps
module hv_driver_core (
	input  wire logic                                          clk_i,
	input  wire logic                                          rst_i,
	hv_link_if.device                                          link,
	input  wire logic [hv_drv_pkg::FAULT_N-1:0]                fault_raw_i,
	output logic      [hv_drv_pkg::CODE_W-1:0]                 out_code_o,
	output logic                                               out_enable_o,
	output logic                                               shutdown_o,
	output logic                                               sleep_o,
	output logic      [hv_drv_pkg::FAULT_N-1:0]                alarm_flags_o,
	output logic      [hv_drv_pkg::FAULT_N-1:0][hv_drv_pkg::LIM_W-1:0] limits_o
);
	import hv_drv_pkg::*;

	logic [CFG_DW-1:0]             ctrl_ff;
	logic [FAULT_N-1:0]            fault_en_ff;
	logic [FAULT_N-1:0]            latch_ff;
	logic [DUR_W-1:0]              dur_ff;
	logic [FAULT_N-1:0][LIM_W-1:0] limits_ff;
	logic [CODE_W-1:0]             pat_mem [PAT_DEPTH];
	logic [PAT_AW-1:0]             ptr_ff;
	logic [CODE_W-1:0]             code_ff;
	logic [FAULT_N-1:0]            flags_ff;
	logic [DUR_W-1:0]              dur_cnt_ff;
	logic                          shutdown_ff;
	logic                          fault_drive_ff;
	logic                          strobe_prev_ff;
	logic                          sdn_prev_ff;
	logic                          forced_prev_ff;
	logic                          clear_prev_ff;
	logic [FAULT_N-1:0]            clr_req;
	logic                          ctrl_wr;
	logic                          pattern_on;
	logic                          armed;
	logic                          asleep;
	logic                          any_fault;
	logic                          trip;
	logic                          strobe_rise;
	logic                          strobe_fall;
	logic                          restart_fall;
	logic                          clear_fall;
	logic                          forced_release;
	logic                          enter_sdn;
	logic                          exit_sdn;
	logic [PAT_AW-1:0]             last_idx;

	function automatic logic is_reg(input logic [CFG_AW-1:0] a, input logic [CFG_AW-1:0] r);
		return link.cfg_wr && (a == r);
	endfunction : is_reg

	////////////////////////////////////////////////////////////////////////////
	// configuration writes

	assign ctrl_wr    = is_reg(link.cfg_addr, REG_CTRL);
	assign pattern_on = ctrl_ff[CTRL_PATTERN_BIT];
	assign armed      = ctrl_ff[CTRL_ARM_BIT];
	assign asleep     = !ctrl_ff[CTRL_SLEEP_BIT];
	assign last_idx   = ctrl_ff[CTRL_LAST_LSB +: PAT_AW];
	assign clr_req    = is_reg(link.cfg_addr, REG_ALARM_CLR) ? link.cfg_data[FAULT_N-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff     <= CTRL_RESET;
			fault_en_ff <= FAULT_EN_RESET;
			latch_ff    <= '0;
			dur_ff      <= DUR_RESET;
		end else begin
			if (ctrl_wr) begin
				ctrl_ff <= link.cfg_data;
			end
			if (is_reg(link.cfg_addr, REG_FAULT_EN)) begin
				fault_en_ff <= link.cfg_data[FAULT_N-1:0];
			end
			if (is_reg(link.cfg_addr, REG_LATCH)) begin
				latch_ff <= link.cfg_data[FAULT_N-1:0];
			end
			if (is_reg(link.cfg_addr, REG_DURATION)) begin
				dur_ff <= link.cfg_data[DUR_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			limits_ff <= {FAULT_N{LIM_RESET}};
		end else begin
			for (int i = 0; i < FAULT_N; i++) begin
				if (is_reg(link.cfg_addr, REG_LIM_BASE + CFG_AW'(i))) begin
					limits_ff[i] <= link.cfg_data[LIM_W-1:0];
				end
			end
		end
	end

	// pattern table; contents are not reset, software loads them first
	always_ff @(posedge clk_i) begin
		if (link.cfg_wr && link.cfg_addr[CFG_AW-1] && !rst_i) begin
			pat_mem[link.cfg_addr[PAT_AW-1:0]] <= link.cfg_data[CODE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// edge detection of the link pins

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_prev_ff <= 1'b0;
			sdn_prev_ff    <= 1'b0;
			forced_prev_ff <= 1'b0;
			clear_prev_ff  <= 1'b0;
		end else begin
			strobe_prev_ff <= link.strobe;
			sdn_prev_ff    <= link.sdn_level;
			forced_prev_ff <= link.sdn_forced_low;
			clear_prev_ff  <= link.clear_pin;
		end
	end

	assign strobe_rise    = link.strobe && !strobe_prev_ff;
	assign strobe_fall    = !link.strobe && strobe_prev_ff;
	assign clear_fall     = !link.clear_pin && clear_prev_ff;
	assign forced_release = !link.sdn_forced_low && forced_prev_ff;
	// restart takes effect when the second write drops the bit
	assign restart_fall   = ctrl_wr && ctrl_ff[CTRL_RESTART_BIT] && !link.cfg_data[CTRL_RESTART_BIT];

	////////////////////////////////////////////////////////////////////////////
	// waveform input

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_ff <= '0;
		end else if (strobe_rise) begin
			code_ff <= pattern_on ? pat_mem[ptr_ff] : link.bus_level;
		end
	end

	// advance on fall, wrap at last level
	always_ff @(posedge clk_i) begin
		if (rst_i || !pattern_on) begin
			ptr_ff <= '0;
		end else if (strobe_fall) begin
			ptr_ff <= (ptr_ff >= last_idx) ? '0 : ptr_ff + 1'b1;
		end
	end

	// device owns the bus in pattern mode
	assign link.dev_bus_out  = pattern_on ? pat_mem[ptr_ff] : '0;
	assign link.dev_bus_oe_n = !pattern_on;

	////////////////////////////////////////////////////////////////////////////
	// protection

	// any enabled fault type raises the alarm
	assign any_fault = |(fault_raw_i & fault_en_ff);

	// self-clearing or latched flags; a new fault beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (latch_ff & flags_ff & ~clr_req) | (fault_raw_i & fault_en_ff);
		end
	end

	// continuous-duration counter, saturates at the limit
	always_ff @(posedge clk_i) begin
		if (rst_i || !any_fault || !armed) begin
			dur_cnt_ff <= '0;
		end else if (dur_cnt_ff < dur_ff) begin
			dur_cnt_ff <= dur_cnt_ff + 1'b1;
		end
	end

	// only an armed system may trip
	assign trip = armed && any_fault && (dur_cnt_ff >= dur_ff);

	assign exit_sdn  = clear_fall || restart_fall || forced_release;
	assign enter_sdn = !asleep && (trip || (link.sdn_level && !sdn_prev_ff));

	// entry wins so a persisting fault cannot be cleared away
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shutdown_ff <= 1'b0;
		end else if (enter_sdn) begin
			shutdown_ff <= 1'b1;
		end else if (exit_sdn) begin
			shutdown_ff <= 1'b0;
		end
	end

	// a trip pulls the shared pin high so the controller sees it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_drive_ff <= 1'b0;
		end else if (!asleep && trip) begin
			fault_drive_ff <= 1'b1;
		// let go while the host holds the pin low, else its release would read as a new rise
		end else if (exit_sdn || link.sdn_forced_low) begin
			fault_drive_ff <= 1'b0;
		end
	end

	assign link.dev_sdn_out  = 1'b1;
	assign link.dev_sdn_oe_n = !fault_drive_ff;

	////////////////////////////////////////////////////////////////////////////
	// outputs

	// output floats in shutdown or sleep
	assign out_enable_o  = !shutdown_ff && !asleep;
	assign out_code_o    = code_ff;
	assign shutdown_o    = shutdown_ff;
	assign sleep_o       = asleep;
	assign alarm_flags_o = flags_ff;
	assign limits_o      = limits_ff;
endmodule : hv_driver_core

// >>> verilog/hv_host_ctrl.sv
`timescale 1ns/10ps
module hv_host_ctrl (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	hv_link_if.host          link
);
	import hv_drv_pkg::*;

	typedef enum logic [1:0] {RS_IDLE, RS_SETTLE, RS_SET, RS_CLR} rst_seq_e;

	rst_seq_e          seq_ff;
	logic [7:0]        settle_ff;
	logic              ack_ff;
	logic [31:0]       rdata_ff;
	logic [CFG_DW-1:0] shadow_ff;
	logic              cfg_wr_ff;
	logic [CFG_AW-1:0] cfg_addr_ff;
	logic [CFG_DW-1:0] cfg_data_ff;
	logic              strobe_ff;
	logic [CODE_W-1:0] code_ff;
	logic              code_drv_ff;
	logic [2:0]        pins_ff;
	logic              wr_go;
	logic              rd_go;

	assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && (|wb_sel_i);
	assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;

	// one wait state, then a one-cycle ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff   <= 1'b0;
			rdata_ff <= '0;
		end else begin
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
			if (rd_go) begin
				if (wb_adr_i == WB_CFG) begin
					rdata_ff <= {16'h0000, shadow_ff};
				end else if (wb_adr_i == WB_STROBE) begin
					rdata_ff <= {31'h00000000, strobe_ff};
				end else if (wb_adr_i == WB_CODE) begin
					rdata_ff <= {15'h0000, code_drv_ff, 2'h0, code_ff};
				end else if (wb_adr_i == WB_PINS) begin
					rdata_ff <= {29'h00000000, pins_ff};
				end else if (wb_adr_i == WB_STATUS) begin
					rdata_ff <= {2'h0, link.bus_level, 14'h0000, seq_ff != RS_IDLE, link.sdn_level};
				end else begin
					rdata_ff <= '0;
				end
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// pin and bus levels

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_ff   <= 1'b0;
			code_ff     <= '0;
			code_drv_ff <= 1'b0;
			pins_ff     <= '0;
		end else begin
			if (wr_go && wb_adr_i == WB_STROBE) begin
				strobe_ff <= wb_dat_i[0];
			end
			if (wr_go && wb_adr_i == WB_CODE) begin
				code_ff     <= wb_dat_i[CODE_W-1:0];
				code_drv_ff <= wb_dat_i[WB_CODE_DRV_BIT];
			end
			if (wr_go && wb_adr_i == WB_PINS) begin
				pins_ff <= wb_dat_i[2:0];
			end else if (seq_ff == RS_SETTLE) begin
				// a restart first lets go of the shutdown pin
				pins_ff[0] <= 1'b0;
			end
		end
	end

	assign link.strobe        = strobe_ff;
	assign link.host_bus_out  = code_ff;
	// never drive the bus while the device owns it
	// hold off too while a mode change is still on its way to the device
	assign link.host_bus_oe_n = !(code_drv_ff && !shadow_ff[CTRL_PATTERN_BIT] &&
		!(cfg_wr_ff && cfg_addr_ff == REG_CTRL));
	assign link.host_sdn_out  = pins_ff[1];
	assign link.host_sdn_oe_n = !pins_ff[0];
	assign link.clear_pin     = pins_ff[2];

	////////////////////////////////////////////////////////////////////////////
	// configuration writes and the restart sequence

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_ff    <= RS_IDLE;
			settle_ff <= '0;
		end else begin
			case (seq_ff)
				RS_IDLE: begin
					settle_ff <= '0;
					if (wr_go && wb_adr_i == WB_RESTART) begin
						seq_ff <= RS_SETTLE;
					end
				end
				// let a charged pin fall before leaving shutdown
				RS_SETTLE: begin
					settle_ff <= settle_ff + 1'b1;
					if (!link.sdn_level || settle_ff >= 8'(SDN_SETTLE_CYC)) begin
						seq_ff <= RS_SET;
					end
				end
				RS_SET: begin
					seq_ff <= RS_CLR;
				end
				default: begin
					seq_ff <= RS_IDLE;
				end
			endcase
		end
	end

	// restart as two writes: bit high, then bit low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_wr_ff   <= 1'b0;
			cfg_addr_ff <= '0;
			cfg_data_ff <= '0;
			shadow_ff   <= CTRL_RESET;
		end else begin
			cfg_wr_ff <= 1'b0;
			if (seq_ff == RS_SET || seq_ff == RS_CLR) begin
				cfg_wr_ff   <= 1'b1;
				cfg_addr_ff <= REG_CTRL;
				cfg_data_ff <= shadow_ff;
				cfg_data_ff[CTRL_RESTART_BIT] <= (seq_ff == RS_SET);
			end else if (wr_go && wb_adr_i == WB_CFG) begin
				cfg_wr_ff   <= 1'b1;
				cfg_addr_ff <= wb_dat_i[WB_CFG_ADR_LSB +: CFG_AW];
				cfg_data_ff <= wb_dat_i[CFG_DW-1:0];
				if (wb_dat_i[WB_CFG_ADR_LSB +: CFG_AW] == REG_CTRL) begin
					shadow_ff <= wb_dat_i[CFG_DW-1:0];
				end
			end
		end
	end

	assign link.cfg_wr   = cfg_wr_ff;
	assign link.cfg_addr = cfg_addr_ff;
	assign link.cfg_data = cfg_data_ff;
endmodule : hv_host_ctrl

// >>> dv/hv_link_properties.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module hv_link_properties (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          cfg_wr,
	input  wire logic [hv_drv_pkg::CFG_AW-1:0] cfg_addr,
	input  wire logic [hv_drv_pkg::CFG_DW-1:0] cfg_data,
	input  wire logic                          host_bus_oe_n,
	input  wire logic                          dev_bus_oe_n,
	input  wire logic                          host_sdn_oe_n,
	input  wire logic                          dev_sdn_out,
	input  wire logic                          dev_sdn_oe_n,
	input  wire logic                          sdn_level
);
	import hv_drv_pkg::*;

	logic              ctrl_wr;
	logic [CFG_DW-1:0] ctrl_seen_ff;
	logic [7:0]        rel_cnt_ff;

	assign ctrl_wr = cfg_wr && cfg_addr == REG_CTRL;

	always_ff @(posedge clk_i) begin
		if (rst_i) ctrl_seen_ff <= CTRL_RESET;
		else if (ctrl_wr) ctrl_seen_ff <= cfg_data;
	end

	// saturates so a long idle pin never wraps back under the settle bound
	always_ff @(posedge clk_i) begin
		if (rst_i || !host_sdn_oe_n) rel_cnt_ff <= 8'h00;
		else if (rel_cnt_ff != 8'hFF) rel_cnt_ff <= rel_cnt_ff + 8'h01;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	// bus hand-over, shutdown pin drive and the restart sequence
	pattern_enter_a: assert property (ctrl_wr && cfg_data[CTRL_PATTERN_BIT] |=> !dev_bus_oe_n)
		else $error("bus not driven after entering pattern mode");
	pattern_leave_a: assert property (ctrl_wr && !cfg_data[CTRL_PATTERN_BIT] |=> dev_bus_oe_n)
		else $error("bus still driven after leaving pattern mode");
	bus_no_fight_a: assert property (!dev_bus_oe_n |-> host_bus_oe_n)
		else $error("host drives bus in pattern mode");
	sdn_drive_high_a: assert property (!dev_sdn_oe_n |-> dev_sdn_out)
		else $error("device drives shutdown pin low");
	restart_pair_a: assert property (ctrl_wr && cfg_data[CTRL_RESTART_BIT] |->
		##[1:8] (ctrl_wr && !cfg_data[CTRL_RESTART_BIT]))
		else $error("restart bit not written low again");
	restart_clear_a: assert property (ctrl_wr && !cfg_data[CTRL_RESTART_BIT] && ctrl_seen_ff[CTRL_RESTART_BIT] |->
		cfg_data == (ctrl_seen_ff & 16'hFFFB))
		else $error("restart low write changed other control bits");
	restart_released_a: assert property (ctrl_wr && cfg_data[CTRL_RESTART_BIT] |-> host_sdn_oe_n)
		else $error("restart issued while host drives shutdown pin");
	restart_wait_a: assert property (ctrl_wr && cfg_data[CTRL_RESTART_BIT] |->
		!$past(sdn_level) || rel_cnt_ff >= 8'(SDN_SETTLE_CYC - 2))
		else $error("restart issued before shutdown pin settled");
endmodule : hv_link_properties

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import hv_drv_pkg::*;

	logic                          clk_i;
	logic                          rst_i;
	logic                          wb_cyc;
	logic                          wb_stb;
	logic                          wb_we;
	logic [7:0]                    wb_adr;
	logic [31:0]                   wb_dat;
	logic [31:0]                   wb_rdat;
	logic                          wb_ack;
	logic [31:0]                   rd;
	logic [FAULT_N-1:0]            fault_raw;
	logic [CODE_W-1:0]             out_code;
	logic                          out_enable;
	logic                          shutdown;
	logic                          sleep;
	logic [FAULT_N-1:0]            flags;
	logic [FAULT_N-1:0][LIM_W-1:0] limits;
	logic [CODE_W-1:0]             lvl [PAT_DEPTH];
	int                            num_errors;
	int                            n_checks;

	////////////////////////////////////////////////////////////////////////////////
	hv_link_if hv_link_if_inst ();

	hv_driver_core hv_driver_core_inst (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.link          (hv_link_if_inst),
		.fault_raw_i   (fault_raw),
		.out_code_o    (out_code),
		.out_enable_o  (out_enable),
		.shutdown_o    (shutdown),
		.sleep_o       (sleep),
		.alarm_flags_o (flags),
		.limits_o      (limits)
	);

	hv_host_ctrl hv_host_ctrl_inst (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.wb_cyc_i (wb_cyc),
		.wb_stb_i (wb_stb),
		.wb_we_i  (wb_we),
		.wb_adr_i (wb_adr),
		.wb_dat_i (wb_dat),
		.wb_sel_i (4'hF),
		.wb_dat_o (wb_rdat),
		.wb_ack_o (wb_ack),
		.link     (hv_link_if_inst)
	);

	hv_link_properties hv_link_properties_inst (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.cfg_wr        (hv_link_if_inst.cfg_wr),
		.cfg_addr      (hv_link_if_inst.cfg_addr),
		.cfg_data      (hv_link_if_inst.cfg_data),
		.host_bus_oe_n (hv_link_if_inst.host_bus_oe_n),
		.dev_bus_oe_n  (hv_link_if_inst.dev_bus_oe_n),
		.host_sdn_oe_n (hv_link_if_inst.host_sdn_oe_n),
		.dev_sdn_out   (hv_link_if_inst.dev_sdn_out),
		.dev_sdn_oe_n  (hv_link_if_inst.dev_sdn_oe_n),
		.sdn_level     (hv_link_if_inst.sdn_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
	endtask : ticks

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
			num_errors++;
		end
	endtask : chk

	// called just after an edge; ack is read before that edge's updates land
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		wb(1'b1, adr, dat);
	endtask : wr

	task automatic cfg(input logic [CFG_AW-1:0] idx, input logic [15:0] dat);
		wr(WB_CFG, {11'h000, idx, dat});
		ticks(2);
	endtask : cfg

	task automatic sync_pulse(input logic [CODE_W-1:0] exp);
		wr(WB_STROBE, 32'h0000_0001);
		ticks(2);
		chk("out_code", 32'(exp), 32'(out_code));
		wr(WB_STROBE, 32'h0000_0000);
		ticks(2);
	endtask : sync_pulse

	task automatic leave_sdn(input int way);
		int n;
		n = 0;
		case (way)
			0: begin
				wr(WB_PINS, 32'h0000_0004);
				wr(WB_PINS, 32'h0000_0000);
			end
			1: begin
				wr(WB_RESTART, 32'h0000_0000);
				do begin
					wb(1'b0, WB_STATUS, 32'h0000_0000);
					n++;
				end while (rd[1] !== 1'b0 && n < 100);
				if (n >= 100) num_errors++;
			end
			default: begin
				wr(WB_PINS, 32'h0000_0001);
				wr(WB_PINS, 32'h0000_0000);
			end
		endcase
		ticks(3);
	endtask : leave_sdn

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// the tests take under a thousand cycles
	initial begin
		repeat (30000) @(posedge clk_i);
		num_errors++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_dat = 32'h0000_0000;
		fault_raw = 5'h00;
		num_errors = 0;
		n_checks = 0;
		ticks(8);
		rst_i <= 1'b0;
		ticks(1);
		chk("enable", 32'h1, 32'(out_enable));
		chk("flags", 32'h0, 32'(flags));
		$display("test reset finished");
		for (int i = 0; i < 3; i++) begin
			wr(WB_CODE, 32'h0001_0000 | 32'(14'h3FFF >> (i * 6)));
			sync_pulse(14'h3FFF >> (i * 6));
			wb(1'b0, WB_STATUS, 32'h0000_0000);
			chk("bus_level", 32'(14'h3FFF >> (i * 6)), 32'(rd[29:16]));
		end
		$display("test stream finished");
		wr(WB_CODE, 32'h0000_0000);
		for (int k = 0; k < PAT_DEPTH; k++) begin
			lvl[k] = CODE_W'(k * 16'h0413 + 16'h0005);
			cfg(REG_PAT_BASE + CFG_AW'(k), 16'(lvl[k]));
		end
		cfg(REG_CTRL, 16'h00F9);
		for (int k = 0; k <= PAT_DEPTH; k++) sync_pulse(lvl[k % PAT_DEPTH]);
		cfg(REG_CTRL, 16'h0008);
		$display("test pattern finished");
		for (int i = 0; i < FAULT_N; i++) begin
			chk("limit", 32'(LIM_RESET), 32'(limits[i]));
			cfg(REG_LIM_BASE + CFG_AW'(i), 16'h0030 + 16'(i));
			chk("limit", 32'h30 + 32'(i), 32'(limits[i]));
		end
		$display("test limits finished");
		fault_raw <= 5'h01;
		ticks(40);
		chk("flags", 32'h1, 32'(flags));
		chk("shutdown", 32'h0, 32'(shutdown));
		fault_raw <= 5'h00;
		ticks(3);
		chk("flags", 32'h0, 32'(flags));
		cfg(REG_CTRL, 16'h000A);
		repeat (2) begin
			fault_raw <= 5'h02;
			ticks(16);
			fault_raw <= 5'h00;
			ticks(2);
		end
		chk("shutdown", 32'h0, 32'(shutdown));
		// a masked fault type raises nothing
		cfg(REG_FAULT_EN, 16'h0017);
		fault_raw <= 5'h08;
		ticks(12);
		chk("shutdown", 32'h0, 32'(shutdown));
		chk("flags", 32'h0, 32'(flags));
		fault_raw <= 5'h00;
		cfg(REG_FAULT_EN, 16'h001F);
		cfg(REG_DURATION, 16'h0004);
		fault_raw <= 5'h08;
		ticks(4);
		fault_raw <= 5'h00;
		ticks(2);
		chk("shutdown", 32'h0, 32'(shutdown));
		for (int f = 0; f < FAULT_N; f++) begin
			fault_raw <= FAULT_N'(1 << f);
			ticks(6);
			chk("shutdown", 32'h1, 32'(shutdown));
			chk("enable", 32'h0, 32'(out_enable));
			fault_raw <= 5'h00;
			wb(1'b0, WB_STATUS, 32'h0000_0000);
			chk("pin", 32'h1, 32'(rd[0]));
			leave_sdn(f % 3);
			chk("shutdown", 32'h0, 32'(shutdown));
		end
		wr(WB_PINS, 32'h0000_0003);
		wr(WB_PINS, 32'h0000_0000);
		ticks(2);
		chk("shutdown", 32'h1, 32'(shutdown));
		leave_sdn(0);
		$display("test protection finished");
		cfg(REG_CTRL, 16'h0002);
		chk("sleep", 32'h1, 32'(sleep));
		chk("enable", 32'h0, 32'(out_enable));
		wr(WB_PINS, 32'h0000_0003);
		wr(WB_PINS, 32'h0000_0000);
		fault_raw <= 5'h10;
		ticks(30);
		chk("shutdown", 32'h0, 32'(shutdown));
		fault_raw <= 5'h00;
		cfg(REG_CTRL, 16'h000A);
		chk("sleep", 32'h0, 32'(sleep));
		chk("enable", 32'h1, 32'(out_enable));
		$display("test sleep finished");
		cfg(REG_CTRL, 16'h0008);
		cfg(REG_LATCH, 16'h0004);
		fault_raw <= 5'h04;
		ticks(3);
		fault_raw <= 5'h00;
		ticks(5);
		chk("flags", 32'h4, 32'(flags));
		cfg(REG_ALARM_CLR, 16'h0004);
		chk("flags", 32'h0, 32'(flags));
		$display("test latch finished");
		wr(8'h40, 32'hFFFF_FFFF);
		wb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped", 32'h0, rd);
		wb(1'b0, WB_CFG, 32'h0000_0000);
		chk("ctrl_shadow", 32'h8, rd);
		$display("test registers finished");
		finish_test();
	end
endmodule : tb_top
